// File: call_clear_complement_exec_tb.sv
// Self-checking bench of the execution core, driven over its classic Wishbone port.
// Assumes the design files and the defines header are compiled before it.
`timescale 1ns/1ps
`include "cce_defs.svh"
module call_clear_complement_exec_tb;
    typedef struct {logic [31:0] e; logic [31:0] m; int l;} cce_note_t;
    logic        clk_i;
    logic        rst_n_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    cce_note_t   notes[$];
    cce_note_t   nt;
    int          bad_count  = 0;
    int          n_compared = 0;
    int          wait_n     = 0;
    logic [7:0]  f, v, r, w, n8;
    logic [3:0]  b;
    logic [4:0]  st;
    logic [11:0] base;
    logic [19:0] k;
    logic [20:0] p, tgt;

    cce_core #(.WDOG_W(4), .POST_W(2)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

    task automatic complete_run();
        if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // The latency is counted by the watcher; zero means the caller does not care.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, e, m, input int l);
        int n;
        notes.push_back('{e, m, l});
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (n = 0; n < 200; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n == 200) begin
            bad_count++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input int l);
        wb(1'b1, a, d, 32'h0000_0000, 32'hFFFF_FFFF, l);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        wb(1'b0, a, 32'h0000_0000, e, m, 0);
    endtask

    always @(posedge clk_i) begin
        if (wb_cyc_i && wb_stb_i && wb_ack_o !== 1'b1) wait_n <= wait_n + 1;
        if (wb_ack_o === 1'b1) begin
            wait_n <= 0;
            nt = notes.pop_front();
            chk("answer data", nt.e & nt.m, wb_dat_o & nt.m);
            if (nt.l != 0) chk("answer latency", 32'(nt.l), 32'(wait_n));
        end
    end

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        rst_n_i  = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hF;
        void'($urandom(32'h285deceb));
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(`CCE_ADR_STACK, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
        wr(`CCE_ADR_SHADOW, $urandom, 0);
        rd(`CCE_ADR_SHADOW, 32'h0000_0000, 32'hFFFF_FFFF);
        b = 4'($urandom);
        f = 8'($urandom);
        wr(`CCE_ADR_BANK, 32'(b), 0);
        wr(`CCE_ADR_DADDR, {20'h0_0000, b, f}, 0);
        wr(`CCE_ADR_DDATA, 32'($urandom) | 32'h0000_0001, 0);
        wr(`CCE_ADR_INSTR, {16'h0000, 7'h35, 1'b1, f}, 6);
        rd(`CCE_ADR_DDATA, 32'h0000_0000, 32'h0000_00FF);
        rd(`CCE_ADR_STATUS, 32'h0000_0004, 32'h0000_001F);
        rd(`CCE_ADR_PC, 32'h0000_0002, 32'hFFFF_FFFF);
        wr(`CCE_ADR_CTRL, 32'h0000_0001, 0);
        base = 12'($urandom);
        wr(`CCE_ADR_FSR2, 32'(base), 0);
        for (int d = 0; d < 2; d++) begin
            f = 8'($urandom % 96);
            v = d ? 8'hFF : 8'($urandom);
            r = ~v;
            w = 8'($urandom);
            wr(`CCE_ADR_DADDR, 32'(12'(base + 12'(f))), 0);
            wr(`CCE_ADR_DDATA, 32'(v), 0);
            wr(`CCE_ADR_WREG, 32'(w), 0);
            wr(`CCE_ADR_STATUS, 32'h0000_000B, 0);
            wr(`CCE_ADR_INSTR, {16'h0000, 6'h07, d[0], 1'b0, f}, 6);
            rd(`CCE_ADR_WREG, 32'(d ? w : r), 32'h0000_00FF);
            rd(`CCE_ADR_DDATA, 32'(d ? r : v), 32'h0000_00FF);
            rd(`CCE_ADR_STATUS, {27'h0, r[7], 1'b1, (r == 8'h00), 2'b11}, 32'h0000_001F);
        end
        wr(`CCE_ADR_CTRL, 32'h0000_0000, 0);
        for (int h = 0; h < 2; h++) begin
            f = h ? 8'(8'h60 + $urandom % 160) : 8'($urandom % 96);
            wr(`CCE_ADR_DADDR, {20'h0_0000, (h ? `CCE_SFR_BANK : 4'h0), f}, 0);
            wr(`CCE_ADR_DDATA, 32'($urandom) | 32'h0000_0001, 0);
            wr(`CCE_ADR_INSTR, {16'h0000, 7'h35, 1'b0, f}, 6);
            rd(`CCE_ADR_DDATA, 32'h0000_0000, 32'h0000_00FF);
        end
        // Long idle lets the shortened watchdog and postscaler both wrap.
        repeat (80) @(posedge clk_i);
        rd(`CCE_ADR_WDOG, 32'h0000_0000, 32'h0100_0000);
        wr(`CCE_ADR_INSTR, 32'h0000_0004, 6);
        rd(`CCE_ADR_WDOG, 32'h0300_0000, 32'h0303_0000);
        for (int z = 0; z < 2; z++) begin
            p  = 21'($urandom) & 21'h1F_FFFE;
            n8 = z ? 8'h80 : 8'($urandom);
            tgt = p + 21'd2 + (z ? {{12{n8[7]}}, n8, 1'b0} : 21'd0);
            wr(`CCE_ADR_PC, 32'(p), 0);
            wr(`CCE_ADR_STATUS, z ? 32'h0000_0004 : 32'h0000_0000, 0);
            wr(`CCE_ADR_INSTR, {16'h0000, 8'hE0, n8}, z ? 10 : 6);
            rd(`CCE_ADR_PC, 32'(tgt), 32'hFFFF_FFFF);
        end
        for (int s = 0; s < 2; s++) begin
            p  = 21'($urandom) & 21'h1F_FFFE;
            k  = 20'($urandom);
            w  = 8'($urandom);
            st = 5'($urandom);
            b  = 4'($urandom);
            wr(`CCE_ADR_PC, 32'(p), 0);
            wr(`CCE_ADR_WREG, 32'(w), 0);
            wr(`CCE_ADR_STATUS, 32'(st), 0);
            wr(`CCE_ADR_BANK, 32'(b), 0);
            wr(`CCE_ADR_INSTR, {16'h0000, 7'h76, s[0], k[7:0]}, 6);
            wr(`CCE_ADR_INSTR, {16'h0000, 4'hF, k[19:8]}, 6);
            rd(`CCE_ADR_PC, {11'h000, k, 1'b0}, 32'hFFFF_FFFF);
            rd(`CCE_ADR_STACK, {3'b000, 5'(s + 1), 3'b000, 21'(p + 21'd4)}, 32'hFFFF_FFFF);
            rd(`CCE_ADR_SHADOW, s ? {12'h000, b, 3'b000, st, w} : 32'h0000_0000, 32'hFFFF_FFFF);
        end
        // A second word without the call prefix drops the call: no push, the PC steps over both words.
        wr(`CCE_ADR_PC, 32'(p), 0);
        wr(`CCE_ADR_INSTR, {16'h0000, 7'h76, 1'b1, k[7:0]}, 6);
        wr(`CCE_ADR_INSTR, {16'h0000, 4'h0, k[19:8]}, 6);
        rd(`CCE_ADR_PC, 32'(21'(p + 21'd4)), 32'hFFFF_FFFF);
        rd(`CCE_ADR_STACK, {3'b000, 5'd2, 3'b000, 21'(p + 21'd4)}, 32'hFFFF_FFFF);
        repeat (3) @(posedge clk_i);
        complete_run();
    end
endmodule // call_clear_complement_exec_tb

// File: cce_core.sv
// Execution core for branch-if-zero, call, clear byte, watchdog clear and invert byte.
// Assumes a classic Wishbone master; each instruction word is issued by a write.
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "cce_defs.svh"
module cce_core #(
    parameter int SDEPTH = `CCE_STACK_DEPTH,
    parameter int WDOG_W = `CCE_WDOG_W,
    parameter int POST_W = `CCE_POST_W
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    import cce_pkg::*;

    localparam int AW = `CCE_DMEM_AW;
    localparam int PW = `CCE_PC_W;

    cce_state_t        state_reg;
    logic [1:0]        q_reg;
    logic [15:0]       instr_reg;
    logic [PW-1:0]     pc_reg;
    logic [7:0]        w_reg;
    logic [4:0]        status_reg;
    logic [3:0]        bank_select_reg;
    logic [7:0]        accum_shadow;
    logic [4:0]        flags_shadow;
    logic [3:0]        bank_select_shadow;
    logic [AW-1:0]     fsr2_reg;
    logic [AW-1:0]     daddr_reg;
    logic              ext_en_reg;
    logic [4:0]        peek_idx_reg;
    logic              call_pend_reg;
    logic              call_s_reg;
    logic [7:0]        call_klo_reg;
    logic [WDOG_W-1:0] watchdog_counter;
    logic [POST_W-1:0] post_reg;
    logic              expiry_flag;
    logic              powerdown_flag;
    logic              ack_reg;
    logic [31:0]       dat_reg;

    cce_mem_if #(.AW(AW), .DW(8)) mem ();
    cce_stk_if #(.AW(PW), .PW(`CCE_STACK_PW)) stk ();

    cce_dmem #(.AW(AW), .DW(8)) u_dmem (
        .clk_i (clk_i),
        .m     (mem.mem)
    );

    cce_stack #(.DEPTH(SDEPTH), .AW(PW), .PW(`CCE_STACK_PW)) u_stack (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .s       (stk.stk)
    );

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Bus decode.
    wire wb_req    = wb_cyc_i && wb_stb_i && !ack_reg;
    wire take      = wb_req && (state_reg == ST_IDLE);
    wire sel_ctrl  = (wb_adr_i == `CCE_ADR_CTRL);
    wire sel_instr = (wb_adr_i == `CCE_ADR_INSTR);
    wire sel_pc    = (wb_adr_i == `CCE_ADR_PC);
    wire sel_wreg  = (wb_adr_i == `CCE_ADR_WREG);
    wire sel_stat  = (wb_adr_i == `CCE_ADR_STATUS);
    wire sel_bank  = (wb_adr_i == `CCE_ADR_BANK);
    wire sel_shad  = (wb_adr_i == `CCE_ADR_SHADOW);
    wire sel_stack = (wb_adr_i == `CCE_ADR_STACK);
    wire sel_wdog  = (wb_adr_i == `CCE_ADR_WDOG);
    wire sel_fsr2  = (wb_adr_i == `CCE_ADR_FSR2);
    wire sel_daddr = (wb_adr_i == `CCE_ADR_DADDR);
    wire sel_ddata = (wb_adr_i == `CCE_ADR_DDATA);
    wire sel_peek  = (wb_adr_i == `CCE_ADR_PEEK);

    // Watchdog fields are widened so shortened counters keep the register layout.
    wire [31:0] rd_word =
        sel_ctrl  ? {19'h0_0000, peek_idx_reg, 7'h00, ext_en_reg} :
        sel_instr ? {16'h0000, instr_reg} :
        sel_pc    ? {11'h000, pc_reg} :
        sel_wreg  ? {24'h00_0000, w_reg} :
        sel_stat  ? {27'h000_0000, status_reg} :
        sel_bank  ? {28'h000_0000, bank_select_reg} :
        sel_shad  ? {12'h000, bank_select_shadow, 3'h0, flags_shadow, accum_shadow} :
        sel_stack ? {3'h0, stk.ptr, 3'h0, stk.top} :
        sel_wdog  ? {6'h00, powerdown_flag, expiry_flag, 8'(post_reg), 16'(watchdog_counter)} :
        sel_fsr2  ? {20'h0_0000, fsr2_reg} :
        sel_daddr ? {20'h0_0000, daddr_reg} :
        sel_ddata ? {24'h00_0000, mem.rdata} :
        sel_peek  ? {11'h000, stk.peek} : 32'h0000_0000;

    wire [31:0] wv     = merge(rd_word, wb_dat_i, wb_sel_i);
    wire        wb_wr  = take && wb_we_i;
    wire        issue  = wb_wr && sel_instr;
    wire        ddrd   = take && !wb_we_i && sel_ddata;

    // Instruction decode.
    wire [7:0] f_lit  = instr_reg[7:0];
    wire       a_bit  = instr_reg[8];
    wire       d_bit  = instr_reg[9];
    wire       call_ok = (instr_reg[15:12] == `CCE_OP_CALL2);
    cce_op_t   op;
    assign op = call_pend_reg                          ? OP_CALL2 :
                (instr_reg[15:8] == `CCE_OP_BRZ)       ? OP_BRZ :
                (instr_reg[15:9] == `CCE_OP_CALL1)     ? OP_CALL1 :
                (instr_reg[15:9] == `CCE_OP_CLRB)      ? OP_CLRB :
                (instr_reg == `CCE_OP_WDCLR)           ? OP_WDCLR :
                (instr_reg[15:10] == `CCE_OP_INVB)     ? OP_INVB : OP_NONE;

    wire          ex_fire = (state_reg == ST_EXEC) && (q_reg == `CCE_Q_LAST);
    wire          indexed = !a_bit && ext_en_reg && (f_lit <= `CCE_ACC_LAST);
    wire [AW-1:0] ea = a_bit   ? {bank_select_reg, f_lit} :
                       indexed ? fsr2_reg + {4'h0, f_lit} :
                       (f_lit <= `CCE_ACC_LAST) ? {4'h0, f_lit} : {`CCE_SFR_BANK, f_lit};
    wire [7:0]    inv = ~mem.rdata;
    wire          z_now = status_reg[`CCE_ST_Z];
    wire [PW-1:0] pc_seq = pc_reg + `CCE_PC_STEP;
    wire [PW-1:0] br_tgt = pc_seq + {{12{f_lit[7]}}, f_lit, 1'h0};
    wire [PW-1:0] call_tgt = {instr_reg[11:0], call_klo_reg, 1'h0};
    wire          brz_taken = (op == OP_BRZ) && z_now;
    wire          call_go = ex_fire && (op == OP_CALL2) && call_ok;
    wire [PW-1:0] pc_next = (op == OP_CALL1) ? pc_reg :
                            (op == OP_CALL2) ? (call_ok ? call_tgt : pc_reg + `CCE_PC_RET) :
                            brz_taken ? br_tgt : pc_seq;

    // Memory and stack wiring.
    wire ex_we = ex_fire && ((op == OP_CLRB) || ((op == OP_INVB) && d_bit));
    assign mem.we        = ex_we || (wb_wr && sel_ddata && wb_sel_i[0]);
    assign mem.waddr     = ex_we ? ea : daddr_reg;
    assign mem.wdata     = ex_we ? ((op == OP_CLRB) ? 8'h00 : inv) : wb_dat_i[7:0];
    assign mem.raddr     = (state_reg == ST_EXEC) ? ea : daddr_reg;
    assign stk.push      = call_go;
    assign stk.push_data = pc_reg + `CCE_PC_RET;
    assign stk.peek_idx  = peek_idx_reg;

    wire wdog_wrap = &watchdog_counter;
    wire post_wrap = &post_reg;

    // Sequencer: four clocks make one instruction cycle.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            q_reg     <= 2'h0;
        end else begin
            q_reg <= q_reg + 2'h1;
            case (state_reg)
                ST_IDLE: begin
                    q_reg <= 2'h0;
                    if (issue) begin
                        state_reg <= ST_EXEC;
                    end else if (ddrd) begin
                        state_reg <= ST_MEMRD;
                    end
                end
                ST_EXEC: begin
                    if (ex_fire) begin
                        state_reg <= brz_taken ? ST_NOP : ST_ACK;
                    end
                end
                ST_NOP: begin
                    if (q_reg == `CCE_Q_LAST) begin
                        state_reg <= ST_ACK;
                    end
                end
                ST_MEMRD: state_reg <= ST_ACK;
                ST_ACK:   state_reg <= ST_IDLE;
                default:  state_reg <= ST_IDLE;
            endcase
        end
    end

    // Bus answer; fast registers answer in the cycle after the request.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_reg <= 1'h0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= (take && !issue && !ddrd) || (state_reg == ST_ACK);
            if ((take && !issue && !ddrd) || (state_reg == ST_ACK)) begin
                dat_reg <= wb_we_i ? 32'h0000_0000 : rd_word;
            end
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // Software-visible configuration.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_en_reg      <= 1'h0;
            peek_idx_reg    <= 5'h00;
            fsr2_reg        <= 12'h000;
            daddr_reg       <= 12'h000;
            bank_select_reg <= 4'h0;
            instr_reg       <= 16'h0000;
        end else begin
            if (wb_wr && sel_ctrl) begin
                ext_en_reg   <= wv[0];
                peek_idx_reg <= wv[12:8];
            end
            if (wb_wr && sel_fsr2) fsr2_reg <= wv[11:0];
            if (wb_wr && sel_daddr) daddr_reg <= wv[11:0];
            if (wb_wr && sel_bank) bank_select_reg <= wv[3:0];
            if (issue) instr_reg <= wv[15:0];
        end
    end

    // Program counter, accumulator and flags.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_reg     <= '0;
            w_reg      <= 8'h00;
            status_reg <= 5'h00;
        end else begin
            if (wb_wr && sel_pc) pc_reg <= {wv[20:1], 1'h0};
            else if (ex_fire) pc_reg <= pc_next;
            if (wb_wr && sel_wreg) w_reg <= wv[7:0];
            else if (ex_fire && (op == OP_INVB) && !d_bit) w_reg <= inv;
            if (wb_wr && sel_stat) begin
                status_reg <= wv[4:0];
            end else if (ex_fire && (op == OP_CLRB)) begin
                status_reg[`CCE_ST_Z] <= 1'h1;
            end else if (ex_fire && (op == OP_INVB)) begin
                status_reg[`CCE_ST_N] <= inv[7];
                status_reg[`CCE_ST_Z] <= (inv == 8'h00);
            end
        end
    end

    // Call state and fast shadows.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            call_pend_reg      <= 1'h0;
            call_s_reg         <= 1'h0;
            call_klo_reg       <= 8'h00;
            accum_shadow       <= 8'h00;
            flags_shadow       <= 5'h00;
            bank_select_shadow <= 4'h0;
        end else if (ex_fire) begin
            if (op == OP_CALL1) begin
                call_pend_reg <= 1'h1;
                call_s_reg    <= instr_reg[8];
                call_klo_reg  <= f_lit;
            end else if (op == OP_CALL2) begin
                call_pend_reg <= 1'h0;
                if (call_ok && call_s_reg) begin
                    accum_shadow       <= w_reg;
                    flags_shadow       <= status_reg;
                    bank_select_shadow <= bank_select_reg;
                end
            end
        end
    end

    // Watchdog; a clear in the wrap cycle wins so the flag stays set.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            watchdog_counter <= '0;
            post_reg         <= '0;
            expiry_flag      <= 1'h1;
            powerdown_flag   <= 1'h1;
        end else if (ex_fire && (op == OP_WDCLR)) begin
            watchdog_counter <= '0;
            post_reg         <= '0;
            expiry_flag      <= 1'h1;
            powerdown_flag   <= 1'h1;
        end else begin
            watchdog_counter <= watchdog_counter + 1'h1;
            if (wdog_wrap) post_reg <= post_reg + 1'h1;
            if (wdog_wrap && post_wrap) expiry_flag <= 1'h0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_CALL_DECODE: assert property (
        take && wb_we_i && sel_instr && !call_pend_reg && (wb_dat_i[15:9] == `CCE_OP_CALL1) |-> ##5 call_pend_reg)
        else $error("first call word did not arm the second word");
    AST_CALL_PC: assert property (call_go |=> pc_reg == $past(call_tgt) && state_reg == ST_ACK)
        else $error("call did not load the target in its second cycle");
    AST_CALL_PUSH: assert property (call_go && !stk.full |=> stk.top == $past(pc_reg) + `CCE_PC_RET)
        else $error("call pushed a wrong return address");
    AST_SHADOW_SAVE: assert property (call_go && call_s_reg |=> accum_shadow == $past(w_reg) &&
        flags_shadow == $past(status_reg) && bank_select_shadow == $past(bank_select_reg))
        else $error("fast call did not save shadows");
    AST_SHADOW_HOLD: assert property (call_go && !call_s_reg |=> $stable(accum_shadow) &&
        $stable(flags_shadow) && $stable(bank_select_shadow))
        else $error("plain call changed shadows");
    AST_CLEAR_BYTE: assert property (ex_fire && op == OP_CLRB |-> mem.we && mem.wdata == 8'h00 &&
        mem.waddr == ea ##1 status_reg[`CCE_ST_Z] && state_reg == ST_ACK)
        else $error("clear byte misbehaved");
    AST_BANK: assert property (state_reg == ST_EXEC && a_bit |-> mem.raddr == {bank_select_reg, f_lit})
        else $error("banked address wrong");
    AST_INDEX: assert property (state_reg == ST_EXEC && !a_bit && ext_en_reg && f_lit <= `CCE_ACC_LAST
        |-> mem.raddr == fsr2_reg + {4'h0, f_lit})
        else $error("indexed offset address wrong");
    AST_WDOG_CLEAR: assert property (ex_fire && op == OP_WDCLR |=> watchdog_counter == '0 && post_reg == '0 &&
        expiry_flag && powerdown_flag)
        else $error("watchdog clear incomplete");
    AST_INV_W: assert property (ex_fire && op == OP_INVB && !d_bit |-> !mem.we ##1
        w_reg == ~$past(mem.rdata))
        else $error("invert to W wrong");
    AST_INV_F: assert property (ex_fire && op == OP_INVB && d_bit |-> mem.we && mem.wdata == ~mem.rdata)
        else $error("invert to memory wrong");
    AST_INV_FLAGS: assert property (ex_fire && op == OP_INVB |=> status_reg[`CCE_ST_N] == ~$past(mem.rdata[7]) &&
        status_reg[`CCE_ST_Z] == ($past(mem.rdata) == 8'hFF) && status_reg[1:0] == $past(status_reg[1:0]) &&
        status_reg[`CCE_ST_OV] == $past(status_reg[`CCE_ST_OV]))
        else $error("invert flags wrong");
    AST_BRZ_NOT: assert property (ex_fire && op == OP_BRZ && !z_now |=> pc_reg == $past(pc_reg) + `CCE_PC_STEP
        && state_reg == ST_ACK)
        else $error("untaken branch wrong");
    AST_BRZ_TAKEN: assert property (ex_fire && brz_taken |=> pc_reg == $past(br_tgt) && state_reg == ST_NOP
        ##1 (state_reg == ST_NOP)[*3] ##1 state_reg == ST_ACK)
        else $error("taken branch wrong");
    AST_CALL_DROP: assert property (ex_fire && op == OP_CALL2 && !call_ok |-> !stk.push ##1
        pc_reg == $past(pc_reg) + `CCE_PC_RET && state_reg == ST_ACK)
        else $error("bad second call word was not dropped");
    AST_CALL_ARM: assert property (ex_fire && op == OP_CALL1 |=> $stable(pc_reg) && $stable(stk.ptr) &&
        call_pend_reg)
        else $error("first call word moved the program counter or pushed");
    AST_ACCESS_LOW: assert property (state_reg == ST_EXEC && !a_bit && !ext_en_reg && f_lit <= `CCE_ACC_LAST
        |-> mem.raddr == {4'h0, f_lit})
        else $error("low access bank address wrong");
    AST_ACCESS_HIGH: assert property (state_reg == ST_EXEC && !a_bit && f_lit > `CCE_ACC_LAST
        |-> mem.raddr == {`CCE_SFR_BANK, f_lit})
        else $error("high access bank address wrong");
    AST_CLEAR_KEEP: assert property (ex_fire && op == OP_CLRB |=> status_reg[1:0] == $past(status_reg[1:0]) &&
        status_reg[4:3] == $past(status_reg[4:3]))
        else $error("clear byte changed other flags");
endmodule // cce_core

// File: cce_defs.svh
// Constants of the call, clear and complement execution block.
// Assumes it is included by bare name from every file that needs the numbers.
// Contract
// - Call reaches any address of 2-Mbyte space.
// - Call pushes own address plus four first.
// - Fast-save bit 1 copies W, flags, bank.
// - Fast-save bit 0 leaves shadows untouched.
// - Call loads 20-bit target into PC 20:1.
// - Call is two words, 1110110s then 1111.
// - Clear byte writes zero, sets Z, one cycle.
// - Access bit picks access bank or bank register.
// - Extended set, access, f<=95 uses indexed offset.
// - Watchdog clear zeroes counters, sets both power flags.
// - Invert byte yields bitwise inverse of byte.
// - Destination 0 puts result in W only.
// - Destination 1 writes result back to memory.
// - Zero branch taken only when Z is one.
// - Taken branch target is PC plus 2 plus 2n.
`ifndef CCE_DEFS_SVH
`define CCE_DEFS_SVH

// Register byte offsets on the bus.
`define CCE_ADR_CTRL     8'h00
`define CCE_ADR_INSTR    8'h04
`define CCE_ADR_PC       8'h08
`define CCE_ADR_WREG     8'h0C
`define CCE_ADR_STATUS   8'h10
`define CCE_ADR_BANK     8'h14
`define CCE_ADR_SHADOW   8'h18
`define CCE_ADR_STACK    8'h1C
`define CCE_ADR_WDOG     8'h20
`define CCE_ADR_FSR2     8'h24
`define CCE_ADR_DADDR    8'h28
`define CCE_ADR_DDATA    8'h2C
`define CCE_ADR_PEEK     8'h30

// Flag positions in the status register.
`define CCE_ST_C         0
`define CCE_ST_DC        1
`define CCE_ST_Z         2
`define CCE_ST_OV        3
`define CCE_ST_N         4

// Opcode patterns.
`define CCE_OP_BRZ       8'hE0
`define CCE_OP_CALL1     7'h76
`define CCE_OP_CALL2     4'hF
`define CCE_OP_CLRB      7'h35
`define CCE_OP_WDCLR     16'h0004
`define CCE_OP_INVB      6'h07

// Addressing and sizes.
`define CCE_ACC_LAST     8'h5F
`define CCE_SFR_BANK     4'hF
`define CCE_DMEM_AW      12
`define CCE_PC_W         21
`define CCE_STACK_DEPTH  31
`define CCE_STACK_PW     5
`define CCE_WDOG_W       16
`define CCE_POST_W       8
`define CCE_PC_STEP      21'h0_0002
`define CCE_PC_RET       21'h0_0004
`define CCE_Q_LAST       2'h3

`endif

// File: cce_dmem.sv
// Byte-wide data memory with one write port and one registered read port.
// Assumes a read during a write to the same address returns the old byte.
`timescale 1ns/1ps
module cce_dmem #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input  wire logic clk_i,
    cce_mem_if.mem    m
);
    logic [DW-1:0] mem_r [2**AW];

    always_ff @(posedge clk_i) begin
        if (m.we) begin
            mem_r[m.waddr] <= m.wdata;
        end
        m.rdata <= mem_r[m.raddr];
    end
endmodule // cce_dmem

// File: cce_if.sv
// Carriers between the core and its data memory and return stack.
// Assumes one controller and one target on each.
`timescale 1ns/1ps
interface cce_mem_if #(parameter int AW = 12, parameter int DW = 8) ();
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport ctl (output we, waddr, wdata, raddr, input rdata);
    modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

interface cce_stk_if #(parameter int AW = 21, parameter int PW = 5) ();
    logic          push;
    logic [AW-1:0] push_data;
    logic [PW-1:0] peek_idx;
    logic [AW-1:0] peek;
    logic [AW-1:0] top;
    logic [PW-1:0] ptr;
    logic          full;
    modport ctl (output push, push_data, peek_idx, input peek, top, ptr, full);
    modport stk (input push, push_data, peek_idx, output peek, top, ptr, full);
endinterface

// File: cce_pkg.sv
// Types shared by the execution block.
// Assumes the defines header is compiled alongside.
package cce_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_NOP, ST_MEMRD, ST_ACK} cce_state_t;
    typedef enum logic [2:0] {OP_NONE, OP_BRZ, OP_CALL1, OP_CALL2, OP_CLRB, OP_WDCLR, OP_INVB} cce_op_t;
endpackage

// File: cce_stack.sv
// Hardware return stack with a readable top and a peek port.
// Assumes pushes arrive one at a time; a push onto a full stack is dropped.
`timescale 1ns/1ps
module cce_stack #(
    parameter int DEPTH = 31,
    parameter int AW    = 21,
    parameter int PW    = 5
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    cce_stk_if.stk    s
);
    logic [AW-1:0] ent_r [DEPTH];
    logic [PW-1:0] ptr_reg;
    logic [AW-1:0] top_reg;
    logic [AW-1:0] peek_reg;
    wire           do_push = s.push && !s.full;

    assign s.full = (ptr_reg == PW'(DEPTH));
    assign s.top  = top_reg;
    assign s.ptr  = ptr_reg;
    assign s.peek = peek_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_reg <= '0;
            top_reg <= '0;
        end else if (do_push) begin
            ptr_reg <= ptr_reg + 1'h1;
            top_reg <= s.push_data;
        end
    end

    // Entries carry no reset so the array can map onto plain storage.
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            ent_r[ptr_reg] <= s.push_data;
        end
        peek_reg <= (s.peek_idx < PW'(DEPTH)) ? ent_r[s.peek_idx] : '0;
    end
endmodule // cce_stack
